/* src/sweep_regs.svh */
// Constants for the frequency sweep controller.
// Assumes a single 100 MHz clock; included by bare name.
`ifndef SWEEP_REGS_SVH
`define SWEEP_REGS_SVH
// Clock period in ns
`define SWEEP_CLK_NS     10
// Dwell per frequency step in ns
`define SWEEP_DWELL_NS   1000
// Fraction bits of the log ratio
`define SWEEP_LOG_FRAC   16
// Divider: load cycle 0, iterations 1..32
`define SWEEP_DIV_LOAD   6'h00
`define SWEEP_DIV_LAST   6'h20
// Reset values and the one-tick minimum
`define SWEEP_RST_WORD   32'h0000_0000
`define SWEEP_RST_STEPS  16'h0000
`define SWEEP_ONE_STEP   16'h0001
`endif

/* src/sweep_pkg.sv */
// Types shared by the sweep controller and its bench.
// Assumes sweep_regs.svh for numeric constants.
package sweep_pkg;
  typedef logic [31:0] freq_t;   // Phase increment word
  typedef logic [15:0] steps_t;  // Time in dwell ticks
  // Trigger source
  typedef enum logic [1:0] {
    SRC_INT = 2'h0, SRC_MAN = 2'h1, SRC_EXT = 2'h2
  } src_e;
  // External trigger edge
  typedef enum logic {EDGE_RISE = 1'h0, EDGE_FALL = 1'h1} edge_e;
  // Trigger output mode
  typedef enum logic [1:0] {
    TOUT_OFF = 2'h0, TOUT_RISE = 2'h1, TOUT_FALL = 2'h2
  } tout_e;
  // Sweep sequencer states
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01, ST_DIV = 6'h02, ST_SWEEP = 6'h04,
    ST_HOLD  = 6'h08, ST_RET = 6'h10, ST_GAP   = 6'h20
  } state_e;
  // Sweep configuration
  typedef struct packed {
    freq_t  start;     // Start frequency word
    freq_t  stop;      // Stop frequency word
    freq_t  marker;    // Marker frequency word
    logic   log_mode;  // 1: logarithmic steps
    steps_t ratio;     // Log step fraction, Q0.16
    steps_t sweep_t;   // Sweep time
    steps_t hold_t;    // Hold time
    steps_t ret_t;     // Return time
    steps_t gap_t;     // Interval time
    src_e   src;       // Trigger source
    edge_e  edge_sel;  // External edge
    tout_e  tout;      // Trigger output mode
  } sweep_cfg_s;
endpackage : sweep_pkg

/* src/frequency_sweep_controller.sv */
// Frequency sweep sequencer driving a phase accumulator.
// Assumes config is stable while a sweep runs; ext_trig is async.
`timescale 1ns/1ps
`include "sweep_regs.svh"
module frequency_sweep_controller #(
  parameter int DWELL_CYCLES = (`SWEEP_DWELL_NS + `SWEEP_CLK_NS - 1)
                               / `SWEEP_CLK_NS
)(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Configuration
  input  wire sweep_pkg::sweep_cfg_s cfg,
  // Triggers
  input  wire logic                 manual_trig,
  input  wire logic                 ext_trig,
  // Oscillator and markers
  output sweep_pkg::freq_t          freq_q,
  output sweep_pkg::freq_t          phase_q,
  output logic                      trig_out_q,
  output logic                      sync_q,
  output logic                      busy_q
);
  import sweep_pkg::*;

  if (DWELL_CYCLES < 1 || DWELL_CYCLES > 65535)
  begin : g_bad_dwell
    $error("DWELL_CYCLES out of range");
  end

  localparam logic [15:0] DWELL_LAST = 16'(DWELL_CYCLES - 1);

  //////////////////////////////////////////////////////////////////
  // Helpers
  //////////////////////////////////////////////////////////////////
  // Zero time is served as one tick
  function automatic steps_t at_least_one(input steps_t t);
    at_least_one = (t == `SWEEP_RST_STEPS) ? `SWEEP_ONE_STEP : t;
  endfunction : at_least_one

  // Move f by s toward tgt, never past it
  function automatic freq_t toward(input freq_t f, input freq_t s,
                                   input logic up, input freq_t tgt);
    logic [32:0] sum;
    sum = {1'b0, f} + {1'b0, s};
    if (up)
      toward = (sum[32] || sum[31:0] > tgt) ? tgt : sum[31:0];
    else
      toward = (s > f || (f - s) < tgt) ? tgt : f - s;
  endfunction : toward

  // Log step: proportional to the present frequency
  function automatic freq_t log_step(input freq_t f, input steps_t r);
    logic [47:0] prod;
    prod = f * r;
    log_step = prod[47:`SWEEP_LOG_FRAC];
    if (log_step == `SWEEP_RST_WORD)
      log_step = 32'h0000_0001;
  endfunction : log_step

  //////////////////////////////////////////////////////////////////
  // Declarations
  //////////////////////////////////////////////////////////////////
  state_e      st_q;        // Sequencer state
  sweep_cfg_s  cfg_q;       // Config latched at sweep start
  logic [15:0] tmr_q;       // Cycle within dwell
  steps_t      stp_q;       // Tick within phase
  freq_t       lin_step_q;  // Sweep increment
  freq_t       ret_step_q;  // Return increment
  logic [5:0]  div_cnt_q;   // Divider iteration
  logic        div_pass_q;  // 0: sweep, 1: return
  logic [16:0] div_rem_q;   // Partial remainder
  freq_t       div_num_q;   // Shifting dividend/quotient
  logic        ext_meta_q;  // Synchroniser stage 1
  logic        ext_sync_q;  // Synchroniser stage 2
  logic        ext_prev_q;  // Edge history
  logic        marker_q;    // Marker already crossed

  //////////////////////////////////////////////////////////////////
  // Combinational decode
  //////////////////////////////////////////////////////////////////
  wire logic   up      = cfg_q.start < cfg_q.stop;
  wire freq_t  delta   = up ? cfg_q.stop - cfg_q.start
                            : cfg_q.start - cfg_q.stop;
  wire logic   tick    = tmr_q == DWELL_LAST;
  wire steps_t n_sweep = at_least_one(cfg_q.sweep_t);
  wire steps_t n_ret   = at_least_one(cfg_q.ret_t);
  wire steps_t n_hold  = at_least_one(cfg_q.hold_t);
  wire steps_t n_gap   = at_least_one(cfg_q.gap_t);
  wire logic   div_end = div_cnt_q == `SWEEP_DIV_LAST;
  // Sweep step by type
  wire freq_t  sw_step = cfg_q.log_mode
                         ? log_step(freq_q, cfg_q.ratio)
                         : lin_step_q;
  // Marker crossing in the sweep direction
  wire logic   passed  = up ? freq_q >= cfg_q.marker
                            : freq_q <= cfg_q.marker;
  // External active edge, only honoured for the external source
  wire logic   ext_rise = ext_sync_q & ~ext_prev_q;
  wire logic   ext_fall = ~ext_sync_q & ext_prev_q;
  wire logic   ext_edge = (cfg.edge_sel == EDGE_FALL)
                          ? ext_fall : ext_rise;
  logic go;
  // Start request by source, taken only in idle
  always_comb
  begin
    go = 1'b0;
    unique case (cfg.src)
      SRC_INT: go = 1'b1;
      SRC_MAN: go = manual_trig;
      SRC_EXT: go = ext_edge;
      default: go = 1'b0;
    endcase
  end
  wire logic phase_end =
    tick && stp_q == ((st_q == ST_SWEEP) ? n_sweep - 16'h1 :
                      (st_q == ST_HOLD)  ? n_hold  - 16'h1 :
                      (st_q == ST_RET)   ? n_ret   - 16'h1 :
                                           n_gap   - 16'h1);

  //////////////////////////////////////////////////////////////////
  // External trigger synchroniser and edge history
  //////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end
    else
    begin
      ext_meta_q <= ext_trig;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Sequencer: states, dwell timer, tick counter
  //////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q  <= ST_IDLE;
      tmr_q <= `SWEEP_RST_STEPS;
      stp_q <= `SWEEP_RST_STEPS;
    end
    else
    begin
      // Dwell timer wraps every DWELL_CYCLES
      tmr_q <= (tick || st_q == ST_IDLE || st_q == ST_DIV)
               ? `SWEEP_RST_STEPS : tmr_q + 16'h1;
      if (tick)
        stp_q <= phase_end ? `SWEEP_RST_STEPS : stp_q + 16'h1;
      unique case (st_q)
        ST_IDLE:
          if (go)
            st_q <= ST_DIV;
        ST_DIV:
          if (div_end && div_pass_q)
          begin
            st_q  <= ST_SWEEP;
            stp_q <= `SWEEP_RST_STEPS;
          end
        ST_SWEEP:
          if (phase_end)
            st_q <= ST_HOLD;
        ST_HOLD:
          if (phase_end)
            st_q <= ST_RET;
        ST_RET:
          if (phase_end)
            st_q <= ST_GAP;
        ST_GAP:
          if (phase_end)
            st_q <= (cfg_q.src == SRC_INT) ? ST_DIV
                                           : ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////
  // Config latch at each sweep start
  //////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (rst)
      cfg_q <= '0;
    else if ((st_q == ST_IDLE && go) ||
             (st_q == ST_GAP && phase_end && cfg_q.src == SRC_INT))
      cfg_q <= cfg;
  end

  //////////////////////////////////////////////////////////////////
  // Restoring divider: delta over tick count, twice per sweep
  //////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin : p_div
    logic [16:0] sh;
    logic [16:0] den;
    sh  = {div_rem_q[15:0], div_num_q[31]};
    den = {1'b0, div_pass_q ? n_ret : n_sweep};
    if (rst)
    begin
      div_cnt_q  <= `SWEEP_DIV_LOAD;
      div_pass_q <= 1'b0;
      div_rem_q  <= '0;
      div_num_q  <= `SWEEP_RST_WORD;
      lin_step_q <= `SWEEP_RST_WORD;
      ret_step_q <= `SWEEP_RST_WORD;
    end
    else if (st_q != ST_DIV)
    begin
      div_cnt_q  <= `SWEEP_DIV_LOAD;
      div_pass_q <= 1'b0;
    end
    else if (div_cnt_q == `SWEEP_DIV_LOAD)
    begin
      div_rem_q <= '0;
      div_num_q <= delta;
      div_cnt_q <= div_cnt_q + 6'h1;
    end
    else
    begin
      // One quotient bit per cycle
      div_rem_q <= (sh >= den) ? sh - den : sh;
      div_num_q <= {div_num_q[30:0], sh >= den};
      div_cnt_q <= div_end ? `SWEEP_DIV_LOAD : div_cnt_q + 6'h1;
      if (div_end)
      begin
        div_pass_q <= 1'b1;
        if (div_pass_q)
          ret_step_q <= {div_num_q[30:0], sh >= den};
        else
          lin_step_q <= {div_num_q[30:0], sh >= den};
      end
    end
  end : p_div

  //////////////////////////////////////////////////////////////////
  // Frequency word: stepped once per dwell tick
  //////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (rst)
      freq_q <= `SWEEP_RST_WORD;
    else
      unique case (st_q)
        ST_IDLE, ST_DIV:
          freq_q <= cfg_q.start;
        ST_SWEEP:
          if (phase_end)
            freq_q <= cfg_q.stop;
          else if (tick)
            freq_q <= toward(freq_q, sw_step, up,
                             cfg_q.stop);
        ST_HOLD:
          freq_q <= cfg_q.stop;
        ST_RET:
          if (phase_end)
            freq_q <= cfg_q.start;
          else if (tick)
            freq_q <= toward(freq_q, ret_step_q, ~up,
                             cfg_q.start);
        ST_GAP:
          freq_q <= cfg_q.start;
      endcase
  end

  //////////////////////////////////////////////////////////////////
  // Phase accumulator: free running, only the increment changes
  //////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (rst)
      phase_q <= `SWEEP_RST_WORD;
    else
      phase_q <= phase_q + freq_q;
  end

  //////////////////////////////////////////////////////////////////
  // Sync, trigger output and busy flag
  //////////////////////////////////////////////////////////////////
  wire logic entering = st_q == ST_DIV && div_end && div_pass_q;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync_q     <= 1'b0;
      trig_out_q <= 1'b0;
      marker_q   <= 1'b0;
      busy_q     <= 1'b0;
    end
    else
    begin
      busy_q <= st_q != ST_IDLE;
      if (entering)
      begin
        // Sweep start point
        sync_q     <= 1'b1;
        trig_out_q <= cfg_q.tout == TOUT_RISE;
        marker_q   <= 1'b0;
      end
      else if ((st_q == ST_SWEEP || st_q == ST_HOLD) && passed &&
               !marker_q)
      begin
        // Marker crossing; the final snap to stop is only seen in the
        // first hold cycle, so a marker passed by that snap still counts
        sync_q     <= 1'b0;
        trig_out_q <= cfg_q.tout == TOUT_FALL;
        marker_q   <= 1'b1;
      end
      else if (cfg_q.tout == TOUT_OFF)
        trig_out_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Checks
  //////////////////////////////////////////////////////////////////
  logic [31:0] sw_cyc_q;  // Cycles spent in the sweep phase
  always_ff @(posedge clk)
  begin
    if (rst || st_q != ST_SWEEP)
      sw_cyc_q <= 32'h0;
    else
      sw_cyc_q <= sw_cyc_q + 32'h1;
  end

  phase_cont_a: assert property (
    @(posedge clk) disable iff (rst)
    !$past(rst) |-> phase_q == $past(phase_q) + $past(freq_q))
    else $error("phase accumulator jumped");

  sweep_len_a: assert property (
    @(posedge clk) disable iff (rst)
    (st_q == ST_SWEEP ##1 st_q == ST_HOLD) |->
    $past(sw_cyc_q) + 32'h1 == 32'(n_sweep) * 32'(DWELL_CYCLES))
    else $error("sweep time wrong");

  up_dir_a: assert property (
    @(posedge clk) disable iff (rst)
    (st_q == ST_SWEEP && up) ##1 st_q == ST_SWEEP |->
    freq_q >= $past(freq_q))
    else $error("upward sweep went down");

  down_dir_a: assert property (
    @(posedge clk) disable iff (rst)
    (st_q == ST_SWEEP && !up) ##1 st_q == ST_SWEEP |->
    freq_q <= $past(freq_q))
    else $error("downward sweep went up");

  lin_step_a: assert property (
    @(posedge clk) disable iff (rst)
    (st_q == ST_SWEEP && !cfg_q.log_mode && up && tick &&
     !phase_end && freq_q + lin_step_q <= cfg_q.stop) |=>
    freq_q == $past(freq_q) + lin_step_q)
    else $error("linear step not equal");

  log_step_a: assert property (
    @(posedge clk) disable iff (rst)
    (st_q == ST_SWEEP && cfg_q.log_mode && up && tick &&
     !phase_end && freq_q < cfg_q.stop - sw_step) |=>
    freq_q - $past(freq_q) == log_step($past(freq_q), cfg_q.ratio))
    else $error("log step wrong");

  hold_stop_a: assert property (
    @(posedge clk) disable iff (rst)
    st_q == ST_HOLD ##1 st_q == ST_HOLD |-> freq_q == cfg_q.stop)
    else $error("hold not at stop");

  ret_start_a: assert property (
    @(posedge clk) disable iff (rst)
    st_q == ST_GAP ##1 st_q == ST_GAP |-> freq_q == cfg_q.start)
    else $error("return did not reach start");

  trig_off_a: assert property (
    @(posedge clk) disable iff (rst)
    cfg_q.tout == TOUT_OFF && $past(cfg_q.tout) == TOUT_OFF |=>
    !trig_out_q)
    else $error("trigger out pulsed while off");

  sync_rise_a: assert property (
    @(posedge clk) disable iff (rst)
    entering |=> sync_q && st_q == ST_SWEEP)
    else $error("sync not raised at start");

  manual_wait_a: assert property (
    @(posedge clk) disable iff (rst)
    st_q == ST_IDLE && cfg.src == SRC_MAN && !manual_trig |=>
    st_q == ST_IDLE)
    else $error("sweep without manual trigger");

  int_repeat_a: assert property (
    @(posedge clk) disable iff (rst)
    st_q == ST_GAP && phase_end && cfg_q.src == SRC_INT |=>
    st_q == ST_DIV)
    else $error("internal source did not repeat");

  sweep_c: cover property (@(posedge clk) disable iff (rst)
    st_q == ST_SWEEP ##1 st_q == ST_HOLD);
  ext_c: cover property (@(posedge clk) disable iff (rst)
    st_q == ST_IDLE && cfg.src == SRC_EXT && ext_edge);
  marker_c: cover property (@(posedge clk) disable iff (rst)
    $fell(sync_q) && st_q == ST_SWEEP);
endmodule : frequency_sweep_controller

/* verification/trig_source.sv */
// External trigger source model for the sweep controller.
// Assumes the bench requests levels; edges land off the clock grid.
`timescale 1ns/1ps
module trig_source #(
  parameter int MIN_CYC = 150
)(
  // Clock and request
  input  wire logic clk,
  input  wire logic lvl_req,
  // Trigger pin
  output logic      ext_trig
);
  int gap;  // Cycles since the last edge

  initial
  begin
    ext_trig = 1'b0;
    gap      = MIN_CYC;
  end

  // Hold a new level back until the sweep cycle has surely ended
  always @(posedge clk)
  begin
    if (lvl_req !== ext_trig && gap >= MIN_CYC)
    begin
      ext_trig <= #3 lvl_req;
      gap = 0;
    end
    else if (gap < MIN_CYC)
      gap = gap + 1;
  end
endmodule : trig_source

/* verification/frequency_sweep_controller_test.sv */
// Self-checking bench for the frequency sweep controller.
// Assumes a small dwell count; a monitor checks every sweep it sees.
`timescale 1ns/1ps
module frequency_sweep_controller_test;
  import sweep_pkg::*;
  localparam int D = 2;  // Dwell cycles used in simulation
  localparam int DIV_CYC = 66;  // Step division ahead of each sweep

  logic       clk, rst, manual_trig, ext_trig, lvl_req;
  sweep_cfg_s cfg, n;           // Driven config, current note
  freq_t      freq_q, phase_q;  // Oscillator outputs
  logic       trig_out_q, sync_q, busy_q;
  sweep_cfg_s notes[$];         // Expected sweeps
  int         error_cnt, samples_checked, cyc, rise_cyc;
  int         tick, cross_tick, done_cnt, mode, exp_per;
  logic       up, crossed, have_rise, ph_ok, prev_sync;
  freq_t      prev_ph, prev_f, step, last_step, sum, lin_exp;
  logic [15:0] seed;

  frequency_sweep_controller #(.DWELL_CYCLES(D))
    frequency_sweep_controller_inst (
    .clk(clk), .rst(rst), .cfg(cfg), .manual_trig(manual_trig),
    .ext_trig(ext_trig), .freq_q(freq_q), .phase_q(phase_q),
    .trig_out_q(trig_out_q), .sync_q(sync_q), .busy_q(busy_q));

  trig_source #(.MIN_CYC(150)) trig_source_inst (
    .clk(clk), .lvl_req(lvl_req), .ext_trig(ext_trig));

  //////////////////////////////////////////////////////////////////////////
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  //////////////////////////////////////////////////////////////////////////
  // Stimulus helpers
  function automatic logic [15:0] lfsr_next(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // Random linear range, or fixed log range; note expected sweeps
  task automatic setup(src_e s, bit upw, bit lg, tout_e t, edge_e e,
                       int copies);
    freq_t base, delta;
    seed  = lfsr_next(seed);
    base  = 32'h0001_0000 + {16'h0000, seed};
    delta = {21'h000000, seed[7:0], 3'h0} + 32'h8;
    cfg.log_mode = lg;
    cfg.ratio    = 16'h1000;
    cfg.sweep_t  = lg ? 16'h0008 : 16'h0004;
    cfg.hold_t   = 16'h0002;
    cfg.ret_t    = 16'h0002;
    cfg.gap_t    = 16'h0003;
    cfg.src      = s;
    cfg.edge_sel = e;
    cfg.tout     = t;
    cfg.start    = lg ? 32'h0000_03e8 : (upw ? base : base + delta);
    cfg.stop     = lg ? 32'h0000_0fa0 : (upw ? base + delta : base);
    cfg.marker   = cfg.start / 2 + cfg.stop / 2;
    repeat (copies) notes.push_back(cfg);
  endtask : setup

  task automatic pulse();
    manual_trig = 1'b1;
    @(negedge clk);
    manual_trig = 1'b0;
  endtask : pulse

  // Bounded wait for completed cycles, optionally for idle too
  task automatic wait_done(int target, bit idle);
    int i;
    for (i = 0; i < 3000 && (done_cnt < target ||
         (idle && busy_q !== 1'b0)); i++)
      @(negedge clk);
    if (i == 3000)
    begin
      cmp("completion wait", 1, 0);
      report_and_stop();
    end
  endtask : wait_done

  //////////////////////////////////////////////////////////////////////////
  // Monitor: follows each sweep against the oldest note
  always @(posedge clk)
  begin
    #1;
    cyc++;
    if (rst)
    begin
      ph_ok = 0;
      mode = 0;
      have_rise = 0;
    end
    else
    begin
      sum = prev_ph + prev_f;
      if (ph_ok)
        cmp("phase", sum, phase_q);
      if (sync_q && !prev_sync)
      begin
        if (notes.size() == 0)
          cmp("unexpected sweep", 0, 1);
        else
        begin
          n = notes.pop_front();
          exp_per = DIV_CYC + D * (n.sweep_t + n.hold_t + n.ret_t + n.gap_t);
          if (have_rise && n.src == SRC_INT)
            cmp("period", exp_per, cyc - rise_cyc);
          rise_cyc = cyc;
          have_rise = 1;
          up = n.start < n.stop;
          cmp("start freq", n.start, freq_q);
          cmp("trig at start", n.tout == TOUT_RISE, trig_out_q);
          mode = 1;
          tick = 0;
          last_step = 0;
          crossed = 0;
        end
      end
      else if (mode == 1)
      begin
        tick++;
        if (freq_q !== prev_f)
        begin
          step = up ? freq_q - prev_f : prev_f - freq_q;
          cmp("direction", 1, up ? freq_q > prev_f : freq_q < prev_f);
          cmp("dwell", 0, tick % D);
          lin_exp = (up ? n.stop - n.start : n.start - n.stop) / n.sweep_t;
          if (freq_q !== n.stop && !n.log_mode)
            cmp("lin step", lin_exp, step);
          else if (freq_q !== n.stop)
            cmp("log growth", 1, step >= last_step);
          last_step = step;
        end
        if (!crossed && (up ? freq_q >= n.marker : freq_q <= n.marker))
        begin
          crossed = 1;
          cross_tick = cyc;
        end
        if (freq_q === n.stop)
        begin
          cmp("sweep time", n.sweep_t * D, tick);
          mode = 2;
          tick = 0;
        end
      end
      else if (mode == 2)
      begin
        tick++;
        if (freq_q === n.start)
        begin
          cmp("hold return", (n.hold_t + n.ret_t) * D, tick);
          mode = 3;
          done_cnt++;
        end
      end
      else if (mode == 3)
      begin
        cmp("rest freq", n.start, freq_q);
        if (busy_q === 1'b0)
        begin
          // Back to idle: the next sweep has no period to check
          mode = 0;
          have_rise = 0;
        end
      end
      if (!sync_q && prev_sync && mode != 0)
      begin
        cmp("marker", 1, crossed && cyc - cross_tick == 1);
        cmp("trig at marker", n.tout == TOUT_FALL, trig_out_q);
      end
      if (mode != 0 && n.tout == TOUT_OFF)
        cmp("trig off", 0, trig_out_q);
      ph_ok = 1;
    end
    prev_ph = phase_q;
    prev_f = freq_q;
    prev_sync = sync_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst = 1'b1;
    manual_trig = 1'b0;
    lvl_req = 1'b0;
    seed = 16'hdb61;
    cfg = '0;
    cfg.src = SRC_MAN;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    // Manual up sweep; a second press while busy is ignored
    setup(SRC_MAN, 1, 0, TOUT_RISE, EDGE_FALL, 1);
    pulse();
    repeat (20) @(negedge clk);
    pulse();
    wait_done(1, 1);
    // Manual down sweep, falling trigger output
    setup(SRC_MAN, 0, 0, TOUT_FALL, EDGE_RISE, 1);
    pulse();
    wait_done(2, 1);
    // Manual log sweep, trigger output off
    setup(SRC_MAN, 1, 1, TOUT_OFF, EDGE_RISE, 1);
    pulse();
    wait_done(3, 1);
    // External rising edge starts; the falling edge does not
    setup(SRC_EXT, 1, 0, TOUT_RISE, EDGE_RISE, 1);
    lvl_req = 1'b1;
    wait_done(4, 1);
    lvl_req = 1'b0;
    repeat (200) @(negedge clk);
    // External falling edge starts; the rising edge does not
    setup(SRC_EXT, 1, 0, TOUT_FALL, EDGE_FALL, 0);
    lvl_req = 1'b1;
    repeat (200) @(negedge clk);
    notes.push_back(cfg);
    lvl_req = 1'b0;
    wait_done(5, 1);
    // Internal source repeats; reset cuts the run in the gap
    setup(SRC_INT, 1, 0, TOUT_FALL, EDGE_RISE, 3);
    wait_done(8, 0);
    rst = 1'b1;
    cfg.src = SRC_MAN;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (100) @(negedge clk);
    cmp("pending sweeps", 0, notes.size());
    cmp("idle busy", 0, busy_q);
    report_and_stop();
  end
endmodule : frequency_sweep_controller_test
